// File: irq_regs.sv
// sticky write-one-to-clear status bits with mask and level interrupt
`timescale 1ns/100ps
module irq_regs (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [modevt_pkg::IRQ_N-1:0] set,
	input wire logic [modevt_pkg::IRQ_N-1:0] clr,
	input wire logic mask_we,
	input wire logic [modevt_pkg::IRQ_N-1:0] mask_d,
	output logic [modevt_pkg::IRQ_N-1:0] stat_q,
	output logic [modevt_pkg::IRQ_N-1:0] mask_q,
	output logic irq
);
	genvar i;
	generate
		for (i = 0; i < modevt_pkg::IRQ_N; i++)
		begin : g_bit
			// set wins over a clear in the same cycle
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					stat_q[i] <= 1'b0;
				else if (set[i])
					stat_q[i] <= 1'b1;
				else if (clr[i])
					stat_q[i] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			mask_q <= '0;
		else if (mask_we)
			mask_q <= mask_d;
	end

	assign irq = |(stat_q & mask_q);
endmodule

// File: modevt_pkg.sv
// constants, register map and state encoding of the periodic event generator
package modevt_pkg;
	localparam int CLK_PERIOD_NS = 8;
	localparam int INT_TICK_NS = 1000;
	localparam int NET_TICK_NS = 8;
	localparam int INT_DIV = (INT_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NET_DIV = (NET_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TS_W = 64;
	localparam int ADR_W = 8;
	localparam int IRQ_N = 2;
	localparam logic [ADR_W-1:0] A_CTRL = 8'h00;
	localparam logic [ADR_W-1:0] A_CMD = 8'h04;
	localparam logic [ADR_W-1:0] A_START_LO = 8'h08;
	localparam logic [ADR_W-1:0] A_START_HI = 8'h0c;
	localparam logic [ADR_W-1:0] A_IVAL_LO = 8'h10;
	localparam logic [ADR_W-1:0] A_IVAL_HI = 8'h14;
	localparam logic [ADR_W-1:0] A_FIRST_LO = 8'h18;
	localparam logic [ADR_W-1:0] A_FIRST_HI = 8'h1c;
	localparam logic [ADR_W-1:0] A_SNAP_LO = 8'h20;
	localparam logic [ADR_W-1:0] A_SNAP_HI = 8'h24;
	localparam logic [ADR_W-1:0] A_STATUS = 8'h28;
	localparam logic [ADR_W-1:0] A_IRQ_STAT = 8'h2c;
	localparam logic [ADR_W-1:0] A_IRQ_MASK = 8'h30;
	localparam int B_ENABLE = 0;
	localparam int B_NET_SEL = 1;
	localparam int B_ZERO = 0;
	localparam int B_SNAP = 1;
	localparam int B_ST_ARMED = 0;
	localparam int B_ST_RUN = 1;
	localparam int B_ST_FIRST = 2;
	localparam int B_IRQ_EVENT = 0;
	localparam int B_IRQ_FIRST = 1;
	localparam logic [TS_W-1:0] TS_ZERO = 64'h0;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ARMED = 3'b010,
		ST_RUN = 3'b100
	} state_t;
endpackage

// File: modevt_top.sv
// periodic event generator on a selectable timestamp base, wishbone slave
`timescale 1ns/100ps
module modevt_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [modevt_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic periodic_event,
	output logic irq
);
	localparam int W = modevt_pkg::TS_W;
	localparam logic [W-1:0] TS_ZERO_C = modevt_pkg::TS_ZERO;

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic ack_q;
	logic [31:0] dat_q;
	logic req;
	logic wr;
	logic [31:0] bmask;
	logic [modevt_pkg::ADR_W-1:0] adr;

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i;
	assign adr = {wb_adr_i[modevt_pkg::ADR_W-1:2], 2'b00};
	assign bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
		input logic [31:0] d);
		merge = (old & ~m) | (d & m);
	endfunction

	// ------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------
	logic enable_q;
	logic network_sync_select;
	logic [W-1:0] periodic_start_time;
	logic [W-1:0] periodic_interval;
	logic [W-1:0] first_event_time;
	logic [W-1:0] counter_snapshot_value;
	logic counter_zero_cmd;
	logic counter_snapshot_cmd;
	logic cmd_hit;

	assign cmd_hit = wr && (adr == modevt_pkg::A_CMD) && wb_sel_i[0];
	assign counter_zero_cmd = cmd_hit && wb_dat_i[modevt_pkg::B_ZERO];
	assign counter_snapshot_cmd = cmd_hit && wb_dat_i[modevt_pkg::B_SNAP];

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			enable_q <= 1'b0;
			network_sync_select <= 1'b0;
		end
		else if (wr && adr == modevt_pkg::A_CTRL && wb_sel_i[0])
		begin
			enable_q <= wb_dat_i[modevt_pkg::B_ENABLE];
			network_sync_select <= wb_dat_i[modevt_pkg::B_NET_SEL];
		end
	end

	// interval writes act at once on the running comparison
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			periodic_start_time <= '0;
			periodic_interval <= '0;
		end
		else if (wr)
		begin
			case (adr)
				modevt_pkg::A_START_LO:
					periodic_start_time[31:0] <= merge(periodic_start_time[31:0], bmask, wb_dat_i);
				modevt_pkg::A_START_HI:
					periodic_start_time[63:32] <= merge(periodic_start_time[63:32], bmask, wb_dat_i);
				modevt_pkg::A_IVAL_LO:
					periodic_interval[31:0] <= merge(periodic_interval[31:0], bmask, wb_dat_i);
				modevt_pkg::A_IVAL_HI:
					periodic_interval[63:32] <= merge(periodic_interval[63:32], bmask, wb_dat_i);
				default:
					periodic_start_time <= periodic_start_time;
			endcase
		end
	end

	// ------------------------------------------------------------
	// time bases
	// ------------------------------------------------------------
	logic [W-1:0] int_time;
	logic [W-1:0] net_time;
	logic [W-1:0] time_sel;
	logic sel_cleared;

	tick_counter #(.DIV(modevt_pkg::INT_DIV)) u_int_cnt (
		.clk(clk),
		.rstn(rstn),
		.clear(counter_zero_cmd),
		.value_q(int_time)
	);

	tick_counter #(.DIV(modevt_pkg::NET_DIV)) u_net_cnt (
		.clk(clk),
		.rstn(rstn),
		.clear(counter_zero_cmd && !network_sync_select),
		.value_q(net_time)
	);

	// one comparator path for both bases, only the source differs
	assign time_sel = network_sync_select ? net_time : int_time;
	assign sel_cleared = counter_zero_cmd && !network_sync_select;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			counter_snapshot_value <= '0;
		else if (counter_snapshot_cmd)
			counter_snapshot_value <= time_sel;
	end

	// ------------------------------------------------------------
	// event sequencer
	// ------------------------------------------------------------
	modevt_pkg::state_t state_q;
	logic [W-1:0] target_q;
	logic calc_done_q;
	logic [W-1:0] last_q;
	logic first_valid_q;
	logic event_q;
	logic fire_first;
	logic fire_run;
	logic [W-1:0] next_due;

	// the target is found by repeated addition from zero, one add per clock;
	// a start time exactly on a multiple therefore lands one interval later
	assign next_due = last_q + periodic_interval;
	assign fire_first = (state_q == modevt_pkg::ST_ARMED) && calc_done_q && !event_q
		&& (time_sel >= target_q);
	assign fire_run = (state_q == modevt_pkg::ST_RUN) && !event_q && !sel_cleared
		&& (time_sel >= next_due);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state_q <= modevt_pkg::ST_IDLE;
		else if (!enable_q)
			state_q <= modevt_pkg::ST_IDLE;
		else
		begin
			case (state_q)
				modevt_pkg::ST_IDLE:
					if (periodic_interval != modevt_pkg::TS_ZERO)
						state_q <= modevt_pkg::ST_ARMED;
				modevt_pkg::ST_ARMED:
					if (fire_first)
						state_q <= modevt_pkg::ST_RUN;
				modevt_pkg::ST_RUN:
					state_q <= modevt_pkg::ST_RUN;
				default:
					state_q <= modevt_pkg::ST_IDLE;
			endcase
		end
	end

	// target survives a counter reset once computed
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			target_q <= '0;
			calc_done_q <= 1'b0;
		end
		else if (state_q != modevt_pkg::ST_ARMED)
		begin
			target_q <= '0;
			calc_done_q <= 1'b0;
		end
		else if (!calc_done_q)
		begin
			if (target_q > periodic_start_time)
				calc_done_q <= 1'b1;
			else
				target_q <= target_q + periodic_interval;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			last_q <= '0;
		else if (fire_first)
			last_q <= target_q;
		else if (state_q == modevt_pkg::ST_RUN && sel_cleared)
			last_q <= '0;
		else if (fire_run)
			last_q <= next_due;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			first_event_time <= '0;
			first_valid_q <= 1'b0;
		end
		else if (fire_first)
		begin
			first_event_time <= time_sel;
			first_valid_q <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			event_q <= 1'b0;
		else
			event_q <= fire_first || fire_run;
	end

	assign periodic_event = event_q;

	// ------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------
	logic [modevt_pkg::IRQ_N-1:0] irq_stat;
	logic [modevt_pkg::IRQ_N-1:0] irq_mask;
	logic [modevt_pkg::IRQ_N-1:0] irq_set;
	logic [modevt_pkg::IRQ_N-1:0] irq_clr;

	assign irq_set = {fire_first, fire_first || fire_run};
	assign irq_clr = (wr && adr == modevt_pkg::A_IRQ_STAT && wb_sel_i[0])
		? wb_dat_i[modevt_pkg::IRQ_N-1:0] : '0;

	irq_regs u_irq (
		.clk(clk),
		.rstn(rstn),
		.set(irq_set),
		.clr(irq_clr),
		.mask_we(wr && adr == modevt_pkg::A_IRQ_MASK && wb_sel_i[0]),
		.mask_d(wb_dat_i[modevt_pkg::IRQ_N-1:0]),
		.stat_q(irq_stat),
		.mask_q(irq_mask),
		.irq(irq)
	);

	// ------------------------------------------------------------
	// read path and acknowledge
	// ------------------------------------------------------------
	logic [31:0] rd;

	always_comb
	begin
		rd = 32'h0;
		case (adr)
			modevt_pkg::A_CTRL:
			begin
				rd[modevt_pkg::B_ENABLE] = enable_q;
				rd[modevt_pkg::B_NET_SEL] = network_sync_select;
			end
			modevt_pkg::A_START_LO: rd = periodic_start_time[31:0];
			modevt_pkg::A_START_HI: rd = periodic_start_time[63:32];
			modevt_pkg::A_IVAL_LO: rd = periodic_interval[31:0];
			modevt_pkg::A_IVAL_HI: rd = periodic_interval[63:32];
			modevt_pkg::A_FIRST_LO: rd = first_event_time[31:0];
			modevt_pkg::A_FIRST_HI: rd = first_event_time[63:32];
			modevt_pkg::A_SNAP_LO: rd = counter_snapshot_value[31:0];
			modevt_pkg::A_SNAP_HI: rd = counter_snapshot_value[63:32];
			modevt_pkg::A_STATUS:
			begin
				rd[modevt_pkg::B_ST_ARMED] = (state_q == modevt_pkg::ST_ARMED);
				rd[modevt_pkg::B_ST_RUN] = (state_q == modevt_pkg::ST_RUN);
				rd[modevt_pkg::B_ST_FIRST] = first_valid_q;
			end
			modevt_pkg::A_IRQ_STAT: rd[modevt_pkg::IRQ_N-1:0] = irq_stat;
			modevt_pkg::A_IRQ_MASK: rd[modevt_pkg::IRQ_N-1:0] = irq_mask;
			default: rd = 32'h0;
		endcase
	end

	// every address answers one clock after the request, unmapped reads zero
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ack_q <= 1'b0;
			dat_q <= '0;
		end
		else
		begin
			ack_q <= req;
			if (req && !wb_we_i)
				dat_q <= rd;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_first_due: assert property (@(posedge clk) disable iff (!rstn)
		fire_first |-> (time_sel >= target_q) && (target_q > TS_ZERO_C))
		else $error("first event before its target");
	a_first_capture: assert property (@(posedge clk) disable iff (!rstn)
		fire_first |=> (first_event_time == $past(time_sel)) && first_valid_q)
		else $error("first event time not captured");
	a_period_step: assert property (@(posedge clk) disable iff (!rstn)
		fire_run |=> (last_q == $past(last_q) + $past(periodic_interval)))
		else $error("period did not advance by interval");
	a_pulse_single: assert property (@(posedge clk) disable iff (!rstn)
		(fire_first || fire_run) |=> periodic_event ##1 !periodic_event)
		else $error("event pulse not single cycle");
	a_target_kept: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == modevt_pkg::ST_ARMED && calc_done_q && enable_q && !fire_first)
		|=> (target_q == $past(target_q)))
		else $error("first event target recomputed");
	a_run_restart: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == modevt_pkg::ST_RUN && sel_cleared) |=> (last_q == TS_ZERO_C))
		else $error("running events did not restart after counter zero");
	a_net_runs: assert property (@(posedge clk) disable iff (!rstn)
		rstn && !(counter_zero_cmd && !network_sync_select)
		|=> (net_time == $past(net_time) + 64'h1))
		else $error("network base did not advance each 8 ns");
	a_int_zero: assert property (@(posedge clk) disable iff (!rstn)
		counter_zero_cmd |=> (int_time == TS_ZERO_C) [*2])
		else $error("internal base not zeroed");
	a_snapshot_copy: assert property (@(posedge clk) disable iff (!rstn)
		counter_snapshot_cmd |=> (counter_snapshot_value == $past(time_sel)))
		else $error("snapshot value mismatch");
endmodule

// File: modevt_top_tb_top.sv
// self-checking bench of the periodic event generator
`timescale 1ns/100ps
module modevt_top_tb_top;
	logic clk;
	logic rstn;
	logic cyc;
	logic stb;
	logic we;
	logic [modevt_pkg::ADR_W-1:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic ack;
	logic ev;
	logic irq;
	logic ev_prev;
	logic [31:0] ival;
	logic [31:0] expq[$];
	int n_fail;
	int total_checks;
	int cyc_n;
	int last_t;
	int last_gap;
	integer seed;

	modevt_top dut (
		.clk(clk),
		.rstn(rstn),
		.wb_cyc_i(cyc),
		.wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(sel),
		.wb_dat_i(dat_i),
		.wb_dat_o(dat_o),
		.wb_ack_o(ack),
		.periodic_event(ev),
		.irq(irq)
	);

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------
	// checking and closing
	// ----------------------------------------
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task results;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// bus master; a read queues its expected data
	// ----------------------------------------
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		if (!w)
			expq.push_back(d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		dat_i <= w ? d : 32'h0;
		@(posedge clk);
		while (ack !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n++;
		end
		chk("ack wait", n < 50, 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	// read data is judged when ack shows, oldest note first
	always @(posedge clk)
	begin
		if (ack === 1'b1 && we === 1'b0)
		begin
			if (expq.size() == 0)
				chk("unexpected read", 1'b1, 1'b0);
			else
				chk("read data", dat_o, expq.pop_front());
		end
	end

	// ----------------------------------------
	// event watch: spacing in clocks, pulse width
	// ----------------------------------------
	always @(posedge clk)
	begin
		cyc_n++;
		if (ev === 1'b1)
		begin
			chk("pulse width", ev_prev, 1'b0);
			last_gap = cyc_n - last_t;
			last_t = cyc_n;
		end
		ev_prev = ev;
	end

	task wait_ev(input int lim);
		int n;
		n = 0;
		@(posedge clk);
		while (ev !== 1'b1 && n < lim)
		begin
			@(posedge clk);
			n++;
		end
		chk("event wait", n < lim, 1'b1);
	endtask

	// gap is read one edge later so the watcher has surely updated it
	task gap_chk(input int exp);
		wait_ev(1000);
		@(posedge clk);
		chk("event gap", last_gap, exp);
	endtask

	initial
	begin
		repeat (40000) @(posedge clk);
		n_fail++;
		results();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		seed = 32'h4b573213;
		rstn = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h0;
		sel = 4'h0;
		dat_i = 32'h0;
		n_fail = 0;
		total_checks = 0;
		cyc_n = 0;
		last_t = 0;
		last_gap = 0;
		ev_prev = 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		chk("irq after reset", irq, 1'b0);
		xfer(1'b0, modevt_pkg::A_CTRL, 32'h0);
		xfer(1'b0, modevt_pkg::A_FIRST_LO, 32'h0);
		xfer(1'b0, modevt_pkg::A_CMD, 32'h0);
		xfer(1'b0, 8'h3c, 32'h0);
		// network base: one tick per clock, so gaps are counted in clocks
		ival = 32'h32 + ($random(seed) & 32'h3f);
		xfer(1'b1, modevt_pkg::A_CMD, 32'h1);
		xfer(1'b1, modevt_pkg::A_START_LO, 32'h3e8);
		xfer(1'b1, modevt_pkg::A_IVAL_LO, ival);
		xfer(1'b1, modevt_pkg::A_CTRL, 32'h3);
		wait_ev(2000);
		gap_chk(ival);
		xfer(1'b0, modevt_pkg::A_FIRST_LO, (32'h3e8 / ival + 32'h1) * ival);
		xfer(1'b0, modevt_pkg::A_STATUS, 32'h6);
		// zero with sync on must leave the network base running on
		xfer(1'b1, modevt_pkg::A_CMD, 32'h1);
		gap_chk(ival);
		xfer(1'b1, modevt_pkg::A_IVAL_LO, ival * 32'h2);
		gap_chk(ival * 2);
		xfer(1'b1, modevt_pkg::A_CTRL, 32'h0);
		chk("irq masked", irq, 1'b0);
		xfer(1'b1, modevt_pkg::A_IRQ_MASK, 32'h3);
		chk("irq unmasked", irq, 1'b1);
		xfer(1'b1, modevt_pkg::A_IRQ_STAT, 32'h3);
		chk("irq cleared", irq, 1'b0);
		xfer(1'b0, modevt_pkg::A_IRQ_STAT, 32'h0);
		// internal base: start 20, interval 10, zero again at 25
		xfer(1'b1, modevt_pkg::A_START_LO, 32'h14);
		xfer(1'b1, modevt_pkg::A_IVAL_LO, 32'ha);
		xfer(1'b1, modevt_pkg::A_CMD, 32'h1);
		xfer(1'b1, modevt_pkg::A_CTRL, 32'h1);
		repeat (25 * modevt_pkg::INT_DIV) @(posedge clk);
		xfer(1'b1, modevt_pkg::A_CMD, 32'h1);
		wait_ev(31 * modevt_pkg::INT_DIV);
		xfer(1'b0, modevt_pkg::A_FIRST_LO, 32'h1e);
		wait_ev(11 * modevt_pkg::INT_DIV);
		xfer(1'b1, modevt_pkg::A_CMD, 32'h2);
		xfer(1'b0, modevt_pkg::A_SNAP_LO, 32'h28);
		xfer(1'b0, modevt_pkg::A_SNAP_HI, 32'h0);
		repeat (5 * modevt_pkg::INT_DIV) @(posedge clk);
		xfer(1'b1, modevt_pkg::A_CMD, 32'h1);
		wait_ev(11 * modevt_pkg::INT_DIV);
		xfer(1'b1, modevt_pkg::A_CMD, 32'h2);
		xfer(1'b0, modevt_pkg::A_SNAP_LO, 32'ha);
		xfer(1'b0, modevt_pkg::A_IRQ_STAT, 32'h3);
		chk("irq on events", irq, 1'b1);
		results();
	end
endmodule

// File: tick_counter.sv
// prescaled free-running 64-bit timestamp counter
`timescale 1ns/100ps
module tick_counter #(
	parameter int DIV = 1
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic clear,
	output logic [modevt_pkg::TS_W-1:0] value_q
);
	localparam int PW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [PW-1:0] LAST = PW'(DIV - 1);
	logic [PW-1:0] pre_q;
	logic tick;

	assign tick = (pre_q == LAST);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pre_q <= '0;
		else if (clear || tick)
			pre_q <= '0;
		else
			pre_q <= pre_q + PW'(1);
	end

	// clear restarts the prescaler too, so the first tick is a full period late
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			value_q <= '0;
		else if (clear)
			value_q <= '0;
		else if (tick)
			value_q <= value_q + 64'h1;
	end
endmodule
